// *** src/sac_ctrl.sv ***
// Converter control unit: registers, sequencer and result storage
`timescale 1ns/1ps
module sac_ctrl (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  srst,
   // Register port
   input  wire sac_pkg::sac_bus_req_s bus_req,
   output logic [7:0]                 rdata,
   // System state
   input  wire logic                  standby_mode,
   input  wire logic                  clock_divider_select,
   // Analog side
   input  wire logic                  comparator_out,
   output sac_pkg::sac_analog_s       analog,
   // Event
   output logic                       conversion_done_interrupt
);
   import sac_pkg::*;

   typedef struct packed {
      logic [7:0]  ctrl_one;
      logic [7:0]  ctrl_two;
      logic [9:0]  result;
      logic        eoc;
      logic        busy;
      sac_phase_e  phase;
      logic [11:0] cnt;
      logic [11:0] total;
      logic [11:0] step;
      logic [9:0]  trial;
      logic [3:0]  bit_idx;
      logic [7:0]  rdata;
      logic        irq;
      logic        cmp_s1;
      logic        cmp_s2;
      logic        stby_s1;
      logic        stby_s2;
      logic        div_s1;
      logic        div_s2;
   } sac_state_s;

   sac_state_s st_ff;
   sac_state_s nxt_st;

   logic [11:0] time_cycles;
   logic        time_reserved;
   logic [1:0]  mode;
   logic        wr_one;
   logic        wr_two;
   logic        start_req;
   logic        step_due;
   logic [11:0] step_len;

   ////////////////////////////////////////////////////////////////////////////
   // Conversion-time lookup

   sac_time_sel sac_time_sel_inst (
      .time_code            (st_ff.ctrl_two[SAC_BIT_TIME_HI:SAC_BIT_TIME_LO]),
      .clock_divider_select (st_ff.div_s2),
      .cycles               (time_cycles),
      .reserved             (time_reserved)
   );

   assign mode      = st_ff.ctrl_one[SAC_BIT_MODE_HI:SAC_BIT_MODE_LO];
   assign wr_one    = bus_req.wr && bus_req.addr == SAC_OFS_CTRL_ONE && !st_ff.stby_s2;
   assign wr_two    = bus_req.wr && bus_req.addr == SAC_OFS_CTRL_TWO && !st_ff.stby_s2;
   // Start bit held in register until picked up by the sequencer
   assign start_req = st_ff.ctrl_one[SAC_BIT_START]
                      && (mode == SAC_MODE_SINGLE || mode == SAC_MODE_REPEAT)
                      && !time_reserved;
   // One bit decision per tenth of the window
   assign step_len  = 12'(st_ff.total / 12'(SAC_RES_BITS));
   assign step_due  = st_ff.step == step_len;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      nxt_st         = st_ff;
      nxt_st.irq     = 1'b0;
      nxt_st.cmp_s1  = comparator_out;
      nxt_st.cmp_s2  = st_ff.cmp_s1;
      nxt_st.stby_s1 = standby_mode;
      nxt_st.stby_s2 = st_ff.stby_s1;
      nxt_st.div_s1  = clock_divider_select;
      nxt_st.div_s2  = st_ff.div_s1;

      // Register writes
      if (wr_one) begin
         nxt_st.ctrl_one = bus_req.wdata;
      end
      if (wr_two) begin
         nxt_st.ctrl_two = bus_req.wdata;
      end

      // Register reads, data in next cycle
      nxt_st.rdata = 8'h00;
      if (bus_req.rd) begin
         case (bus_req.addr)
            SAC_OFS_CTRL_ONE: nxt_st.rdata = st_ff.ctrl_one;
            // Top two bits are undefined on read
            SAC_OFS_CTRL_TWO: nxt_st.rdata = {SAC_UNDEF_READ[7:6],
                                              st_ff.ctrl_two[5:0]};
            // Result low bits, flags, low nibble meaningless
            SAC_OFS_RES_LOW:  nxt_st.rdata = {st_ff.result[1:0], st_ff.eoc, st_ff.busy,
                                              SAC_UNDEF_READ[3:0]};
            SAC_OFS_RES_HIGH: nxt_st.rdata = st_ff.result[9:2];
            default:          nxt_st.rdata = 8'h00;
         endcase
      end

      // Sequencer
      case (st_ff.phase)
         SAC_IDLE: begin
            if (start_req) begin
               nxt_st.phase    = SAC_CONV;
               nxt_st.ctrl_one[SAC_BIT_START] = 1'b0;
               nxt_st.busy     = 1'b1;
               nxt_st.eoc      = 1'b0;
               nxt_st.total    = time_cycles;
               nxt_st.cnt      = 12'h001;
               nxt_st.step     = 12'h001;
               nxt_st.bit_idx  = 4'h9;
               nxt_st.trial    = 10'h200;
            end
         end
         SAC_CONV: begin
            nxt_st.cnt  = st_ff.cnt + 12'h001;
            nxt_st.step = st_ff.step + 12'h001;
            // Window counter runs on; step counter restarts per decision
            if (step_due) begin
               nxt_st.step = 12'h001;
               // Ten decisions only; index 0xf marks all bits resolved
               if (st_ff.bit_idx <= 4'h9) begin
                  // Keep or drop trial bit, then try the next lower one
                  if (!st_ff.cmp_s2) begin
                     nxt_st.trial[st_ff.bit_idx] = 1'b0;
                  end
                  if (st_ff.bit_idx != 4'h0) begin
                     nxt_st.bit_idx = st_ff.bit_idx - 4'h1;
                     nxt_st.trial[st_ff.bit_idx - 4'h1] = 1'b1;
                  end else begin
                     nxt_st.bit_idx = 4'hf;
                  end
               end
            end
            // Completion once the whole window has elapsed
            if (st_ff.cnt == st_ff.total) begin
               nxt_st.result = st_ff.trial;
               nxt_st.eoc    = 1'b1;
               nxt_st.irq    = 1'b1;
               if (mode == SAC_MODE_REPEAT) begin
                  nxt_st.cnt     = 12'h001;
                  nxt_st.step    = 12'h001;
                  nxt_st.total   = time_cycles;
                  nxt_st.bit_idx = 4'h9;
                  nxt_st.trial   = 10'h200;
               end else begin
                  nxt_st.phase = SAC_IDLE;
                  nxt_st.busy  = 1'b0;
               end
            end
            // Disable mode aborts immediately, nothing stored
            if (mode == SAC_MODE_OFF) begin
               nxt_st.phase  = SAC_IDLE;
               nxt_st.busy   = 1'b0;
               nxt_st.result = st_ff.result;
               nxt_st.eoc    = st_ff.eoc;
               nxt_st.irq    = 1'b0;
            end
         end
         default: begin
            nxt_st.phase = SAC_IDLE;
            nxt_st.busy  = 1'b0;
         end
      endcase

      // Reading the high byte clears the end flag; completion wins
      if (bus_req.rd && bus_req.addr == SAC_OFS_RES_HIGH && !nxt_st.irq) begin
         nxt_st.eoc = 1'b0;
      end

      // Standby: abort, reinitialise, block writes
      if (st_ff.stby_s2) begin
         nxt_st.ctrl_one = SAC_RST_CTRL_ONE;
         nxt_st.ctrl_two = SAC_RST_CTRL_TWO;
         nxt_st.phase    = SAC_IDLE;
         nxt_st.busy     = 1'b0;
         nxt_st.eoc      = 1'b0;
         nxt_st.irq      = 1'b0;
         nxt_st.result   = 10'(SAC_RST_RES_HIGH);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff          <= '0;
         st_ff.ctrl_one <= SAC_RST_CTRL_ONE;
         st_ff.ctrl_two <= SAC_RST_CTRL_TWO;
         st_ff.result   <= 10'(SAC_RST_RES_HIGH);
         st_ff.phase    <= SAC_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign rdata                     = st_ff.rdata;
   assign conversion_done_interrupt = st_ff.irq;

   always_comb begin
      analog.sample     = st_ff.busy;
      // Ladder on during conversion, or always when requested
      analog.ladder_on  = st_ff.busy || st_ff.ctrl_two[SAC_BIT_LADDER];
      analog.ain_enable = !st_ff.ctrl_one[SAC_BIT_AIN_DIS];
      analog.channel    = st_ff.ctrl_one[SAC_BIT_CH_HI:SAC_BIT_CH_LO];
      analog.trial      = st_ff.trial;
   end
endmodule

// *** src/sac_pkg.sv ***
// Package: register map, fields, timing counts and carrier types of the converter control
package sac_pkg;
   localparam logic [7:0] SAC_OFS_CTRL_ONE   = 8'h0e;
   localparam logic [7:0] SAC_OFS_CTRL_TWO   = 8'h0f;
   localparam logic [7:0] SAC_OFS_RES_LOW    = 8'h26;
   localparam logic [7:0] SAC_OFS_RES_HIGH   = 8'h27;

   localparam logic [7:0] SAC_RST_CTRL_ONE   = 8'h10;
   localparam logic [7:0] SAC_RST_CTRL_TWO   = 8'h00;
   localparam logic [7:0] SAC_RST_RES_HIGH   = 8'h00;
   localparam logic [7:0] SAC_UNDEF_READ     = 8'h00;

   localparam int SAC_BIT_START   = 7;
   localparam int SAC_BIT_MODE_HI = 6;
   localparam int SAC_BIT_MODE_LO = 5;
   localparam int SAC_BIT_AIN_DIS = 4;
   localparam int SAC_BIT_CH_HI   = 3;
   localparam int SAC_BIT_CH_LO   = 0;
   localparam int SAC_BIT_LADDER  = 5;
   localparam int SAC_BIT_TIME_HI = 3;
   localparam int SAC_BIT_TIME_LO = 1;
   localparam int SAC_RES_BITS    = 10;

   localparam logic [1:0] SAC_MODE_OFF    = 2'h0;
   localparam logic [1:0] SAC_MODE_SINGLE = 2'h1;
   localparam logic [1:0] SAC_MODE_REPEAT = 2'h3;

   // Conversion times in fc cycles, per divider setting
   localparam logic [11:0] SAC_T39   = 12'd39;
   localparam logic [11:0] SAC_T78   = 12'd78;
   localparam logic [11:0] SAC_T156  = 12'd156;
   localparam logic [11:0] SAC_T312  = 12'd312;
   localparam logic [11:0] SAC_T624  = 12'd624;
   localparam logic [11:0] SAC_T1248 = 12'd1248;
   localparam logic [11:0] SAC_T2096 = 12'd2096;

   typedef enum logic [1:0] {
      SAC_IDLE,
      SAC_CONV
   } sac_phase_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sac_bus_req_s;

   typedef struct packed {
      logic       sample;
      logic       ladder_on;
      logic       ain_enable;
      logic [3:0] channel;
      logic [9:0] trial;
   } sac_analog_s;
endpackage

// *** src/sac_time_sel.sv ***
// Conversion-time decoder: time code and divider select to cycle count
`timescale 1ns/1ps
module sac_time_sel (
   // Selection
   input  wire logic [2:0]  time_code,
   input  wire logic        clock_divider_select,
   // Count
   output logic      [11:0] cycles,
   output logic             reserved
);
   import sac_pkg::*;

   always_comb begin
      reserved = 1'b0;
      cycles   = SAC_T39;
      if (!clock_divider_select) begin
         case (time_code)
            3'h0:    cycles = SAC_T39;
            3'h2:    cycles = SAC_T78;
            3'h3:    cycles = SAC_T156;
            3'h4:    cycles = SAC_T312;
            3'h5:    cycles = SAC_T624;
            3'h6:    cycles = SAC_T1248;
            default: reserved = 1'b1;
         endcase
      end else begin
         case (time_code)
            3'h0:    cycles = SAC_T39;
            3'h2:    cycles = SAC_T156;
            3'h3:    cycles = SAC_T312;
            3'h4:    cycles = SAC_T624;
            3'h5:    cycles = SAC_T1248;
            3'h6:    cycles = SAC_T2096;
            default: reserved = 1'b1;
         endcase
      end
   end
endmodule

// *** tb/sac_analog_model.sv ***
// Partner model: sample-hold, ladder and comparator facing the converter
`timescale 1ns/1ps
module sac_analog_model (
   // Clock
   input  wire logic                 clk,
   // Converter side
   input  wire sac_pkg::sac_analog_s analog,
   input  wire logic [9:0]           level,
   output logic                      comparator_out
);
   import sac_pkg::*;
   logic tog_ff = 1'b0;
   always @(posedge clk) tog_ff <= !tog_ff;
   // Channel offsets the level; noise unless converting with the input enabled
   assign comparator_out = (analog.sample && analog.ladder_on && analog.ain_enable) ?
      ((level ^ {6'h00, analog.channel}) >= analog.trial) : tog_ff;
endmodule

// *** tb/sac_ctrl_tb.sv ***
// Testbench: register access, conversion times, repeat, abort and standby
`timescale 1ns/1ps
module sac_ctrl_tb;
   import sac_pkg::*;
   logic         clk = 1'b0;
   logic         srst = 1'b1;
   sac_bus_req_s bus_req = '0;
   logic [7:0]   rdata;
   logic         standby_mode = 1'b0;
   logic         clock_divider_select = 1'b0;
   logic         comparator_out;
   sac_analog_s  analog;
   logic         conversion_done_interrupt;
   logic [9:0]   level = 10'h000;
   logic [9:0]   lv;
   logic [15:0]  exp_q[$];
   logic [15:0]  note;
   logic         rd_d = 1'b0;
   logic [31:0]  seed = 32'd76618;
   int           n;
   int           error_cnt = 0;
   int           checks_done = 0;
   localparam logic [11:0] TT [16] = '{SAC_T39, 12'h0, SAC_T78, SAC_T156, SAC_T312, SAC_T624,
      SAC_T1248, 12'h0, SAC_T39, 12'h0, SAC_T156, SAC_T312, SAC_T624, SAC_T1248, SAC_T2096, 12'h0};
   always #20 clk = ~clk;
   sac_ctrl sac_ctrl_inst (.clk(clk), .srst(srst), .bus_req(bus_req), .rdata(rdata),
      .standby_mode(standby_mode), .clock_divider_select(clock_divider_select),
      .comparator_out(comparator_out), .analog(analog),
      .conversion_done_interrupt(conversion_done_interrupt));
   sac_analog_model sac_analog_model_inst (.clk(clk), .analog(analog), .level(level),
      .comparator_out(comparator_out));
   ////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus_req.wr <= 1'b0;
   endtask
   // Expected value and mask of care bits
   task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] m);
      @(posedge clk);
      exp_q.push_back({e, m});
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
   endtask
   task automatic wirq();
      n = 0;
      @(negedge clk);
      while (conversion_done_interrupt !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      cmp("irq_timeout", 16'h0, {15'h0, n >= 3000});
      @(posedge clk);
   endtask
   task automatic conv(logic dv, logic [2:0] c);
      logic [11:0] t;
      logic [9:0]  r;
      t = TT[{dv, c}];
      seed = xs(seed);
      level <= seed[13:4];
      r = seed[13:4] ^ {6'h00, seed[3:0]};
      clock_divider_select <= dv;
      wr(SAC_OFS_CTRL_TWO, {2'h0, dv, 1'b1, c, 1'b0}); // Fixed bits kept
      wr(SAC_OFS_CTRL_ONE, {4'ha, seed[3:0]}); // Channel set while idle
      wirq();
      cmp("conv_time", 16'h1, {15'h0, n >= t - 1 && n <= t + 3}); // Time table
      rd(SAC_OFS_RES_LOW, {r[1:0], 2'h2, 4'h0}, 8'hf0); // Low bits, flags
      rd(SAC_OFS_RES_HIGH, r[9:2], 8'hff); // High byte
      rd(SAC_OFS_RES_LOW, 8'h00, 8'h30); // Flag cleared by high read
      rd(SAC_OFS_CTRL_ONE, {4'h2, seed[3:0]}, 8'hff); // Start self-clear
      rd(SAC_OFS_CTRL_TWO, {2'h0, dv, 1'b1, c, 1'b0}, 8'h3f); // Read-back
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) rd_d <= bus_req.rd;
   always @(negedge clk) begin
      if (rd_d && exp_q.size() > 0) begin
         note = exp_q.pop_front();
         cmp("rdata", {8'h00, note[15:8] & note[7:0]}, {8'h00, rdata & note[7:0]});
      end
   end
   initial begin
      #(40 * 40000);
      error_cnt++;
      test_done;
   end
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd(SAC_OFS_CTRL_ONE, SAC_RST_CTRL_ONE, 8'hff); // Reset value
      rd(SAC_OFS_CTRL_TWO, SAC_RST_CTRL_TWO, 8'h3f); // Reset value
      rd(SAC_OFS_RES_HIGH, SAC_RST_RES_HIGH, 8'hff); // Reset value
      rd(SAC_OFS_RES_LOW, 8'h00, 8'hf0); // Idle flags
      rd(8'h10, 8'h00, 8'hff);
      for (int d = 0; d < 2; d++) begin
         for (int c = 0; c < 7; c++) begin
            if (c != 1) begin
               conv(d[0], c[2:0]); // Permitted codes only
            end
         end
      end
      wr(SAC_OFS_CTRL_TWO, 8'h12);
      wr(SAC_OFS_CTRL_ONE, 8'ha0);
      repeat (60) @(posedge clk);
      rd(SAC_OFS_RES_LOW, 8'h00, 8'h10); // Reserved code idle
      rd(SAC_OFS_CTRL_ONE, 8'ha0, 8'hff); // Start pending
      wr(SAC_OFS_CTRL_ONE, 8'h00);
      seed = xs(seed);
      lv = seed[9:0];
      level <= lv;
      wr(SAC_OFS_CTRL_TWO, 8'h10);
      wr(SAC_OFS_CTRL_ONE, 8'he0);
      wirq();
      wirq();
      rd(SAC_OFS_RES_LOW, {lv[1:0], 2'h1, 4'h0}, 8'hd0); // Repeat restarts
      level <= ~lv;
      wr(SAC_OFS_CTRL_ONE, 8'h00);
      rd(SAC_OFS_RES_LOW, {lv[1:0], 2'h0, 4'h0}, 8'hd0); // Abort stops
      rd(SAC_OFS_RES_HIGH, lv[9:2], 8'hff); // Partial not stored
      wr(SAC_OFS_CTRL_ONE, 8'ha0);
      wirq();
      level <= lv;
      wr(SAC_OFS_CTRL_ONE, 8'ha0); // Restart before read
      rd(SAC_OFS_RES_LOW, {~lv[1:0], 2'h1, 4'h0}, 8'hf0); // Old result kept
      wirq();
      wr(SAC_OFS_CTRL_TWO, 8'h3c);
      wr(SAC_OFS_CTRL_ONE, 8'ha5);
      repeat (20) @(posedge clk);
      standby_mode <= 1'b1;
      repeat (6) @(posedge clk);
      wr(SAC_OFS_CTRL_ONE, 8'h25);
      rd(SAC_OFS_CTRL_ONE, SAC_RST_CTRL_ONE, 8'hff); // Write refused
      rd(SAC_OFS_CTRL_TWO, SAC_RST_CTRL_TWO, 8'h3f); // Forced value
      rd(SAC_OFS_RES_LOW, 8'h00, 8'hf0); // Busy cleared
      standby_mode <= 1'b0;
      repeat (4) @(posedge clk);
      wr(SAC_OFS_CTRL_ONE, 8'h25);
      rd(SAC_OFS_CTRL_ONE, 8'h25, 8'hff); // Writable again
      repeat (4) @(posedge clk);
      test_done;
   end
endmodule

// *** tb/sac_sva.sv ***
// Checker: register read-back and sequencer relations of the converter control
`timescale 1ns/1ps
module sac_sva (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  srst,
   // Register port
   input wire sac_pkg::sac_bus_req_s bus_req,
   input wire logic [7:0]            rdata,
   // System and analog side
   input wire logic                  standby_mode,
   input wire logic                  clock_divider_select,
   input wire logic                  comparator_out,
   input wire sac_pkg::sac_analog_s  analog,
   input wire logic                  conversion_done_interrupt
);
   import sac_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////////////////////
   AST_LOW_NIBBLE: assert property (
      $past(bus_req.rd) && $past(bus_req.addr) == SAC_OFS_RES_LOW |-> rdata[3:0] == 4'h0)
      else $error("result low nibble not zero");
   AST_TOP_BITS: assert property (
      $past(bus_req.rd) && $past(bus_req.addr) == SAC_OFS_CTRL_TWO |-> rdata[7:6] == 2'h0)
      else $error("control two top bits not zero");
   AST_BUSY_READ: assert property (
      $past(bus_req.rd) && $past(bus_req.addr) == SAC_OFS_RES_LOW
      |-> rdata[4] == $past(analog.sample))
      else $error("busy bit differs from sampling state");
   AST_CH_READ: assert property (
      $past(bus_req.rd) && $past(bus_req.addr) == SAC_OFS_CTRL_ONE
      |-> rdata[4:0] == {!$past(analog.ain_enable), $past(analog.channel)})
      else $error("input control or channel differs from analog side");
   AST_LADDER: assert property (analog.sample |-> analog.ladder_on)
      else $error("ladder off during conversion");
   AST_LADDER_KEEP: assert property (
      $past(bus_req.rd) && $past(bus_req.addr) == SAC_OFS_CTRL_TWO && rdata[5]
      |-> $past(analog.ladder_on))
      else $error("ladder off while always-connect set");
   AST_IRQ_CAUSE: assert property (
      conversion_done_interrupt |-> $past(analog.sample) && !$past(conversion_done_interrupt))
      else $error("interrupt without conversion");
   AST_STANDBY: assert property (
      standby_mode [*4] |=> !analog.sample && analog.channel == 4'h0 && !analog.ain_enable)
      else $error("standby did not reinitialise");
   AST_ABORT: assert property (
      bus_req.wr && bus_req.addr == SAC_OFS_CTRL_ONE && bus_req.wdata[6:5] == SAC_MODE_OFF
      |-> ##1 (!conversion_done_interrupt [*2]) ##[0:1] !analog.sample)
      else $error("disable did not stop conversion");
endmodule
bind sac_ctrl sac_sva sac_sva_inst (.clk(clk), .srst(srst), .bus_req(bus_req),
   .rdata(rdata), .standby_mode(standby_mode), .clock_divider_select(clock_divider_select),
   .comparator_out(comparator_out), .analog(analog),
   .conversion_done_interrupt(conversion_done_interrupt));
